/* File: design/cmc_consts.svh */
// constants for the can mode control block
`ifndef CMC_CONSTS_SVH
`define CMC_CONSTS_SVH
// ==========================================================
// register offsets
`define CMC_ADDR_MODE_CONTROL 3'h0
`define CMC_ADDR_COMMAND_PORT 3'h1
`define CMC_ADDR_STATUS       3'h2
`define CMC_ADDR_IRQ_FLAGS    3'h3
`define CMC_ADDR_QUEUE_START  3'h4
// ==========================================================
// mode_control fields
`define CMC_BIT_INIT_HOLD     0
`define CMC_BIT_RX_IRQ_EN     1
`define CMC_BIT_TX_IRQ_EN     2
`define CMC_BIT_ERR_IRQ_EN    3
`define CMC_BIT_OVR_IRQ_EN    4
`define CMC_BIT_FIXED_ONE     5
`define CMC_BIT_SPARE         6
`define CMC_BIT_MUST_ZERO     7
// ==========================================================
// irq flag fields
`define CMC_IRQ_RX            0
`define CMC_IRQ_TX            1
`define CMC_IRQ_ERR           2
`define CMC_IRQ_OVR           3
// ==========================================================
// values and timing
`define CMC_CMD_READ_VALUE    8'hFF
`define CMC_RAM_ZERO          6'h00
`define CMC_IDLE_BITS         11
`define CMC_BUSOFF_IDLE_COUNT 128
`define CMC_ONE_IDLE_COUNT    1
`endif

/* File: design/cmc_pkg.sv */
// types for the can mode control block
package cmc_pkg;
	typedef enum logic [1:0]
	{
		CMC_INIT,
		CMC_WAIT_IDLE,
		CMC_ACTIVE
	} cmc_mode_e;
	typedef enum logic
	{
		CMC_CAUSE_HOST,
		CMC_CAUSE_BUSOFF
	} cmc_cause_e;
endpackage

/* File: design/cmc_half_clock.sv */
// half-rate internal clock tick generator
`timescale 1ns/100ps
`default_nettype none
module cmc_half_clock
(
	input  wire logic ref_clk, // system clock
	input  wire logic sys_rst, // sync reset, active high
	output var  logic tick     // one ref_clk cycle high per internal edge
);
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			tick <= 1'b0;
		else
			tick <= ~tick;
	end
endmodule
`default_nettype wire

/* File: design/cmc_idle_counter.sv */
// counts bus-free sequences of recessive bits
`timescale 1ns/100ps
`default_nettype none
module cmc_idle_counter #(
	parameter int IDLE_BITS = 11,
	parameter int MAX_COUNT = 128
)
(
	input  wire logic                         ref_clk,   // system clock
	input  wire logic                         sys_rst,   // sync reset, active high
	input  wire logic                         clear,     // restart counting
	input  wire logic                         bit_tick,  // one pulse per bus bit
	input  wire logic                         rx_level,  // sampled bus level, 1 recessive
	output var  logic [$clog2(MAX_COUNT+1)-1:0] idle_seen  // completed bus-free sequences
);
	localparam int BW = $clog2(IDLE_BITS + 1);
	localparam int CW = $clog2(MAX_COUNT + 1);
	logic [BW-1:0] run;

	if (IDLE_BITS < 1 || MAX_COUNT < 1)
	begin
		$error("cmc_idle_counter: counts must be positive");
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || clear)
		begin
			run       <= '0;
			idle_seen <= '0;
		end
		else if (bit_tick)
		begin
			if (!rx_level)
				run <= '0;
			else if (run == BW'(IDLE_BITS - 1))
			begin
				// sequence complete; a longer idle counts again after another full run
				run <= '0;
				if (idle_seen != CW'(MAX_COUNT))
					idle_seen <= idle_seen + CW'(1);
			end
			else
				run <= run + BW'(1);
		end
	end
endmodule
`default_nettype wire

/* File: design/cmc_mode_control.sv */
// mode control, reset handling and receive queue pointers of the can controller
//
// The plain strobed port was decided locally.
`include "cmc_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module cmc_mode_control #(
	parameter int PTR_W = 6
)
(
	input  wire logic             ref_clk,        // 50 MHz system clock
	input  wire logic             sys_rst,        // sync reset, active high
	input  wire logic             hw_reset_n,     // external reset pin, active low
	input  wire logic [2:0]       reg_addr,       // register address
	input  wire logic [7:0]       reg_wdata,      // write data
	input  wire logic             reg_wr,         // write strobe
	input  wire logic             reg_rd,         // read strobe
	output var  logic [7:0]       reg_rdata,      // read data, cycle after strobe
	input  wire logic             bus_off,        // bus status from error logic
	input  wire logic             err_warn,       // error status from error logic
	input  wire logic             overrun,        // data overrun status
	input  wire logic             rx_good,        // pulse: frame received without error
	input  wire logic             tx_done,        // pulse: frame sent successfully
	input  wire logic             tx_buf_free,    // pulse: transmit buffer accessible again
	input  wire logic             frame_store,    // pulse: frame byte written to queue
	input  wire logic             frame_is_tx,    // stored frame is our own transmission
	input  wire logic             queue_release,  // pulse: host released receive window
	input  wire logic [PTR_W-1:0] release_len,    // size of released message
	input  wire logic             bit_tick,       // pulse per bus bit time
	input  wire logic             rx_level,       // sampled bus level, 1 recessive
	output var  logic             reset_mode,     // controller held in reset mode
	output var  logic             abort_frame,    // pulse: abort traffic in progress
	output var  logic             bus_on,         // controller takes part in bus traffic
	output var  logic             irq_n,          // interrupt to host, active low
	output var  logic [PTR_W-1:0] rd_ptr,         // receive queue read pointer
	output var  logic [PTR_W-1:0] wr_ptr,         // receive queue write pointer
	output var  logic             window_locked   // receive window holds a received frame
);
	localparam int CW = $clog2(`CMC_BUSOFF_IDLE_COUNT + 1);

	// pointers must fit the eight-bit read port
	if (PTR_W < 2 || PTR_W > 8)
	begin
		$error("cmc_mode_control: PTR_W out of range");
	end

	// ==========================================================
	// pin synchroniser: three stages, change taken when last two agree
	logic [2:0] pin_sync;
	logic       pin_low;
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			pin_sync <= 3'h7;
			pin_low  <= 1'b0;
		end
		else
		begin
			pin_sync <= {pin_sync[1:0], hw_reset_n};
			if (pin_sync[1] == pin_sync[2])
				pin_low <= ~pin_sync[2];
		end
	end
	logic hard_reset;
	assign hard_reset = sys_rst | pin_low;

	// ==========================================================
	// internal half-rate clock
	logic int_tick;
	cmc_half_clock u_half
	(
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.tick    (int_tick)
	);

	// ==========================================================
	// control register
	logic       ovr_irq_en;
	logic       err_irq_en;
	logic       tx_irq_en;
	logic       rx_irq_en;
	logic       spare_bit;
	logic       init_hold_request;
	logic       hold_pending;
	logic       hold_req_val;
	logic       hold_from_busoff;
	logic       spare_init;
	cmc_pkg::cmc_cause_e hold_cause;

	function automatic logic hit(input logic [2:0] a, input logic [2:0] target);
		return a == target;
	endfunction

	logic wr_ctrl;
	assign wr_ctrl = reg_wr && hit(reg_addr, `CMC_ADDR_MODE_CONTROL);

	always_ff @(posedge ref_clk)
	begin
		if (hard_reset)
		begin
			ovr_irq_en <= 1'b0;
			err_irq_en <= 1'b0;
			tx_irq_en  <= 1'b0;
			rx_irq_en  <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			ovr_irq_en <= reg_wdata[`CMC_BIT_OVR_IRQ_EN];
			err_irq_en <= reg_wdata[`CMC_BIT_ERR_IRQ_EN];
			tx_irq_en  <= reg_wdata[`CMC_BIT_TX_IRQ_EN];
			rx_irq_en  <= reg_wdata[`CMC_BIT_RX_IRQ_EN];
		end
	end

	// spare bit ignores every reset; given a value once so it is never unknown
	// cleared until the first reset has marked it initialised, never after
	always_ff @(posedge ref_clk)
	begin
		if (spare_init)
		begin
			if (wr_ctrl)
				spare_bit <= reg_wdata[`CMC_BIT_SPARE];
		end
		else
			spare_bit <= 1'b0;
	end
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			spare_init <= 1'b1;
	end

	// host writes to the hold bit wait for the internal clock edge
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			hold_pending <= 1'b0;
			hold_req_val <= 1'b1;
		end
		else if (wr_ctrl)
		begin
			hold_pending <= 1'b1;
			hold_req_val <= reg_wdata[`CMC_BIT_INIT_HOLD];
		end
		else if (int_tick)
			hold_pending <= 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (hard_reset)
		begin
			init_hold_request <= 1'b1;
			hold_cause        <= cmc_pkg::CMC_CAUSE_HOST;
		end
		else if (bus_off)
		begin
			init_hold_request <= 1'b1;
			hold_cause        <= cmc_pkg::CMC_CAUSE_BUSOFF;
		end
		else if (hold_pending && int_tick)
		begin
			init_hold_request <= hold_req_val;
			if (hold_req_val && !init_hold_request)
				hold_cause <= cmc_pkg::CMC_CAUSE_HOST;
		end
	end
	assign hold_from_busoff = (hold_cause == cmc_pkg::CMC_CAUSE_BUSOFF);

	// ==========================================================
	// mode sequencing
	cmc_pkg::cmc_mode_e mode;
	logic [CW-1:0]      idle_seen;
	logic [CW-1:0]      idle_need;
	logic               idle_clear;

	assign idle_need  = hold_from_busoff ? CW'(`CMC_BUSOFF_IDLE_COUNT) : CW'(`CMC_ONE_IDLE_COUNT);
	assign idle_clear = (mode != cmc_pkg::CMC_WAIT_IDLE);

	cmc_idle_counter #(
		.IDLE_BITS (`CMC_IDLE_BITS),
		.MAX_COUNT (`CMC_BUSOFF_IDLE_COUNT)
	) u_idle
	(
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.clear     (idle_clear),
		.bit_tick  (bit_tick),
		.rx_level  (rx_level),
		.idle_seen (idle_seen)
	);

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			mode <= cmc_pkg::CMC_INIT;
		else if (init_hold_request)
			mode <= cmc_pkg::CMC_INIT;
		else
		begin
			unique case (mode)
				cmc_pkg::CMC_INIT:
					mode <= cmc_pkg::CMC_WAIT_IDLE;
				cmc_pkg::CMC_WAIT_IDLE:
					if (idle_seen >= idle_need)
						mode <= cmc_pkg::CMC_ACTIVE;
				cmc_pkg::CMC_ACTIVE:
					mode <= cmc_pkg::CMC_ACTIVE;
			endcase
		end
	end

	logic hold_prev;
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			hold_prev   <= 1'b1;
			abort_frame <= 1'b0;
			reset_mode  <= 1'b1;
			bus_on      <= 1'b0;
		end
		else
		begin
			hold_prev   <= init_hold_request;
			abort_frame <= init_hold_request & ~hold_prev;
			reset_mode  <= init_hold_request;
			bus_on      <= (mode == cmc_pkg::CMC_ACTIVE) && !init_hold_request;
		end
	end

	// ==========================================================
	// receive queue pointers
	logic [PTR_W-1:0] queue_start;
	logic             entering_reset;
	assign entering_reset = init_hold_request & ~hold_prev;

	always_ff @(posedge ref_clk)
	begin
		if (hard_reset)
		begin
			queue_start <= PTR_W'(`CMC_RAM_ZERO);
			rd_ptr      <= PTR_W'(`CMC_RAM_ZERO);
			wr_ptr      <= PTR_W'(`CMC_RAM_ZERO);
		end
		else if (entering_reset)
		begin
			rd_ptr <= queue_start;
			wr_ptr <= queue_start;
		end
		else if (!init_hold_request)
		begin
			if (queue_release)
			begin
				rd_ptr      <= rd_ptr + release_len;
				queue_start <= rd_ptr + release_len;
			end
			if (frame_store)
				wr_ptr <= wr_ptr + PTR_W'(1);
		end
	end

	// own frames land in the window but never lock it
	always_ff @(posedge ref_clk)
	begin
		if (hard_reset || entering_reset)
			window_locked <= 1'b0;
		else if (rx_good && !frame_is_tx)
			window_locked <= 1'b1;
		else if (queue_release || (frame_store && frame_is_tx))
			window_locked <= 1'b0;
	end

	// ==========================================================
	// interrupt flags: set wins over the read clear
	logic [3:0] irq_flags;
	logic       rd_flags;
	logic       err_prev;
	logic       boff_prev;
	logic       ovr_prev;
	logic [3:0] irq_set;
	assign rd_flags = reg_rd && hit(reg_addr, `CMC_ADDR_IRQ_FLAGS);

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			err_prev  <= 1'b0;
			boff_prev <= 1'b0;
			ovr_prev  <= 1'b0;
		end
		else
		begin
			err_prev  <= err_warn;
			boff_prev <= bus_off;
			ovr_prev  <= overrun;
		end
	end

	always_comb
	begin
		irq_set                = '0;
		irq_set[`CMC_IRQ_RX]  = rx_irq_en && rx_good && !frame_is_tx;
		irq_set[`CMC_IRQ_TX]  = tx_irq_en && (tx_done || tx_buf_free);
		irq_set[`CMC_IRQ_ERR] = err_irq_en && ((err_warn != err_prev) || (bus_off != boff_prev));
		irq_set[`CMC_IRQ_OVR] = ovr_irq_en && overrun && !ovr_prev;
	end

	always_ff @(posedge ref_clk)
	begin
		if (hard_reset)
			irq_flags <= '0;
		else if (rd_flags)
			irq_flags <= irq_set;
		else
			irq_flags <= irq_flags | irq_set;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			irq_n <= 1'b1;
		else
			irq_n <= ~(|(irq_flags | irq_set));
	end

	// ==========================================================
	// read port
	logic [7:0] ctrl_view;
	assign ctrl_view = {1'b0, spare_bit, 1'b1, ovr_irq_en, err_irq_en, tx_irq_en, rx_irq_en,
		init_hold_request};

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				`CMC_ADDR_MODE_CONTROL: reg_rdata <= ctrl_view;
				`CMC_ADDR_COMMAND_PORT: reg_rdata <= `CMC_CMD_READ_VALUE;
				`CMC_ADDR_STATUS:       reg_rdata <= {bus_off, err_warn, 3'h0, overrun, bus_on, reset_mode};
				`CMC_ADDR_IRQ_FLAGS:    reg_rdata <= {4'h0, irq_flags};
				`CMC_ADDR_QUEUE_START:  reg_rdata <= 8'(queue_start);
				default:                reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	// ==========================================================
	// checks
	cmd_reads_ones_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reg_rd && reg_addr == `CMC_ADDR_COMMAND_PORT |=> reg_rdata == 8'hFF)
		else $error("command port read not all ones");
	fixed_one_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reg_rd && reg_addr == `CMC_ADDR_MODE_CONTROL |=> reg_rdata[5] && !reg_rdata[7])
		else $error("control bit five not one");
	busoff_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		bus_off |=> init_hold_request)
		else $error("bus-off did not force hold");
	pin_blocks_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pin_low |=> init_hold_request)
		else $error("hold cleared under reset pin");
	hold_on_tick_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$fell(init_hold_request) |-> $past(int_tick))
		else $error("hold cleared off internal edge");
	sequence s_enter;
		$rose(init_hold_request);
	endsequence
	enter_abort_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_enter |=> abort_frame ##1 reset_mode)
		else $error("no abort on reset request");
	ptr_home_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(s_enter and !pin_low) |=> rd_ptr == wr_ptr)
		else $error("pointers not returned home");
	ovr_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!ovr_irq_en |=> !irq_flags[`CMC_IRQ_OVR] || $past(irq_flags[`CMC_IRQ_OVR]))
		else $error("overrun flag set while disabled");
	rx_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rx_irq_en && rx_good && !frame_is_tx |=> irq_flags[`CMC_IRQ_RX])
		else $error("receive interrupt missed");
	tx_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		tx_irq_en && tx_done |=> irq_flags[`CMC_IRQ_TX] ##1 !irq_n)
		else $error("transmit interrupt missed");
	busoff_wait_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mode == cmc_pkg::CMC_WAIT_IDLE && hold_from_busoff && idle_seen < CW'(128)
		|=> mode != cmc_pkg::CMC_ACTIVE)
		else $error("bus-on before 128 bus-free");
	one_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mode == cmc_pkg::CMC_WAIT_IDLE && !hold_from_busoff && idle_seen == CW'(0)
		|=> mode != cmc_pkg::CMC_ACTIVE)
		else $error("bus-on without bus-free");
endmodule
`default_nettype wire

/* File: bench/cmc_bus_model.sv */
// far-side bus model: bit timing and sampled bus level
`timescale 1ns/100ps
`default_nettype none
module cmc_bus_model #(
	parameter int TICK_DIV = 4
)
(
	input  wire logic ref_clk,  // system clock
	input  wire logic busy,     // foreign traffic on the bus
	output var  logic bit_tick, // one pulse per bit time
	output var  logic rx_level  // sampled level, 1 recessive
);
	int unsigned div = 0;
	logic        phase = 1'b0;
	// ==========================================================
	// bit timing
	always_ff @(posedge ref_clk)
	begin
		div      <= (div == TICK_DIV - 1) ? 0 : div + 1;
		bit_tick <= (div == TICK_DIV - 1);
	end
	// traffic alternates every bit so no bus-free run can form
	always_ff @(posedge ref_clk)
	begin
		if (bit_tick)
			phase <= ~phase;
	end
	// idle bus is pulled recessive
	assign rx_level = busy ? phase : 1'b1;
endmodule
`default_nettype wire

/* File: bench/can_mode_control_and_reset_test.sv */
// self-checking bench for the can mode control block
`timescale 1ns/100ps
`default_nettype none
module can_mode_control_and_reset_test;
	logic        ref_clk = 1'b0, sys_rst = 1'b1, hw_reset_n = 1'b1;
	logic [2:0]  reg_addr = 3'h0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata;
	logic        reg_wr = 1'b0, reg_rd = 1'b0;
	logic        bus_off = 1'b0, err_warn = 1'b0, overrun = 1'b0, frame_is_tx = 1'b0, busy = 1'b0;
	logic [4:0]  ev = 5'h00;
	logic [5:0]  release_len = 6'h00, qlen, rd_ptr, wr_ptr;
	logic        bit_tick, rx_level, reset_mode, abort_frame, bus_on, irq_n, window_locked;
	logic [31:0] seed = 32'h67F4, r;
	int          num_errors = 0, checks_done = 0, cycles = 0, n;
	// ==========================================================
	// clock, design and far side
	initial forever #10 ref_clk = ~ref_clk;
	cmc_mode_control cmc_mode_control_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .hw_reset_n(hw_reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.bus_off(bus_off), .err_warn(err_warn), .overrun(overrun), .rx_good(ev[0]), .tx_done(ev[1]),
		.tx_buf_free(ev[2]), .frame_store(ev[3]), .frame_is_tx(frame_is_tx), .queue_release(ev[4]),
		.release_len(release_len), .bit_tick(bit_tick), .rx_level(rx_level), .reset_mode(reset_mode),
		.abort_frame(abort_frame), .bus_on(bus_on), .irq_n(irq_n), .rd_ptr(rd_ptr), .wr_ptr(wr_ptr),
		.window_locked(window_locked));
	cmc_bus_model cmc_bus_model_i (.ref_clk(ref_clk), .busy(busy), .bit_tick(bit_tick), .rx_level(rx_level));
	// ==========================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// bit 7 reads 0, bit 5 reads 1
	function automatic logic [7:0] mc_exp(input logic [7:0] w);
		return {1'b0, w[6], 1'b1, w[4:0]};
	endfunction
	function automatic logic [7:0] flag_of(input int k);
		return (k == 0) ? 8'h01 : (k < 3) ? 8'h02 : (k == 3) ? 8'h04 : 8'h08;
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask
	task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input string nm);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1 chk(nm, e, reg_rdata);
	endtask
	task automatic pulse(input int k);
		@(posedge ref_clk);
		ev[k] <= 1'b1;
		@(posedge ref_clk);
		ev    <= 5'h00;
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask
	task automatic wait_on(input int lim);
		n = 0;
		while (bus_on !== 1'b1 && n < lim)
		begin
			@(posedge ref_clk);
			n++;
		end
		#1;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// run is about 6000 cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			stop_test();
		end
	end
	// ==========================================================
	// scenarios
	initial
	begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rdchk(3'h0, 8'h21, "mode_control");
		rdchk(3'h7, 8'h00, "unmapped");
		chk("reset_mode", 8'h01, {7'h00, reset_mode});
		$display("test reset values done");
		r = rnd();
		wr(3'h1, r[15:8]);
		rdchk(3'h1, 8'hFF, "command_port");
		wr(3'h0, {1'b0, r[6:1], 1'b1});
		rdchk(3'h0, mc_exp({1'b0, r[6:1], 1'b1}), "mode_control");
		$display("test register access done");
		@(posedge ref_clk) busy <= 1'b1;
		wr(3'h0, 8'h1E);
		rdchk(3'h0, 8'h3E, "mode_control");
		settle(100);
		chk("reset_mode", 8'h00, {7'h00, reset_mode});
		chk("bus_on busy", 8'h00, {7'h00, bus_on});
		@(posedge ref_clk) busy <= 1'b0;
		wait_on(100);
		chk("bus_on", 8'h01, {7'h00, bus_on});
		$display("test leave reset done");
		for (int en = 0; en < 2; en++)
		begin
			wr(3'h0, en ? 8'h1E : 8'h00);
			for (int k = 0; k < 5; k++)
			begin
				if (k < 3)
					pulse(k);
				else if (k == 3)
					@(posedge ref_clk) err_warn <= ~err_warn;
				else
					@(posedge ref_clk) overrun <= 1'b1;
				settle(3);
				chk("irq_n", {7'h00, en == 0}, {7'h00, irq_n});
				rdchk(3'h3, en ? flag_of(k) : 8'h00, "irq_flags");
				@(posedge ref_clk) overrun <= 1'b0;
			end
		end
		chk("window_locked rx", 8'h01, {7'h00, window_locked});
		repeat (3) pulse(3);
		r    = rnd();
		qlen = r[5:0] | 6'h01;
		@(posedge ref_clk) release_len <= qlen;
		pulse(4);
		@(posedge ref_clk) frame_is_tx <= 1'b1;
		pulse(0);
		settle(3);
		chk("irq_n own frame", 8'h01, {7'h00, irq_n});
		chk("window_locked own frame", 8'h00, {7'h00, window_locked});
		rdchk(3'h3, 8'h00, "irq_flags own frame");
		@(posedge ref_clk) frame_is_tx <= 1'b0;
		$display("test interrupts done");
		wr(3'h0, 8'h1F);
		n = 0;
		while (abort_frame !== 1'b1 && n < 8)
		begin
			@(posedge ref_clk);
			n++;
		end
		chk("abort_frame", 8'h01, {7'h00, abort_frame});
		settle(4);
		chk("reset_mode", 8'h01, {7'h00, reset_mode});
		chk("rd_ptr", {2'b00, qlen}, {2'b00, rd_ptr});
		chk("wr_ptr", {2'b00, qlen}, {2'b00, wr_ptr});
		$display("test soft reset done");
		wr(3'h0, 8'h1E);
		wait_on(150);
		@(posedge ref_clk) bus_off <= 1'b1;
		settle(8);
		rdchk(3'h0, 8'h3F, "mode_control bus-off");
		rdchk(3'h3, 8'h04, "irq_flags bus-off");
		@(posedge ref_clk) bus_off <= 1'b0;
		wr(3'h0, 8'h1E);
		settle(880);
		chk("bus_on early", 8'h00, {7'h00, bus_on});
		wait_on(5900);
		chk("bus_on late", 8'h01, {7'h00, bus_on});
		chk("bus-free wait", 8'h01, {7'h00, (n + 880) >= 5588});
		$display("test bus-off recovery done");
		wr(3'h0, 8'h5F);
		@(posedge ref_clk) hw_reset_n <= 1'b0;
		settle(8);
		wr(3'h0, 8'h40);
		settle(6);
		rdchk(3'h0, 8'h61, "mode_control pin");
		chk("rd_ptr pin", 8'h00, {2'b00, rd_ptr});
		@(posedge ref_clk) hw_reset_n <= 1'b1;
		settle(8);
		@(posedge ref_clk) sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rdchk(3'h0, 8'h61, "mode_control sys_rst");
		$display("test hard reset done");
		stop_test();
	end
endmodule
`default_nettype wire
